// File: hw/osb_hold_timer.sv
// minimum hold timer: restarts on trig, busy until the count runs out
// assumes trig from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module osb_hold_timer #(
  parameter longint HOLD_CYC = 1000
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // control
  input  wire logic trig_i,
  output logic      busy_o
);
  // a zero hold would never start and a wider one would be cut to 32 bits
  if (HOLD_CYC < 1 || HOLD_CYC > 64'h0000_0000_ffff_ffff) begin : g_bad_hold
    $error("osb_hold_timer: HOLD_CYC out of range");
  end
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  // reload on every trigger so the hold runs from the last hot sample
  always_comb begin
    if (trig_i) cnt_nxt = 32'(HOLD_CYC);
    else if (cnt_r != 32'h0) cnt_nxt = cnt_r - 32'h1;
    else cnt_nxt = cnt_r;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) cnt_r <= 32'h0;
    else cnt_r <= cnt_nxt;
  end
  assign busy_o = (cnt_r != 32'h0);
endmodule : osb_hold_timer
`default_nettype wire

// File: hw/osb_status_bank.sv
// option slot status bank: type, version, error status, fan and trips
// assumes apb master on sys_clk_i; module-side inputs are same-domain
// except the presence pin, which is synchronised here
`timescale 1ns/10ps
`default_nettype none
// Contract
// - The type field reads zero while the slot is empty and never exceeds 599.
// - With a module present the type field shows its identity code loaded at power-up.
// - A save (1000 in the save command then stop/reset) stores the installed type code.
// - At power-up a type mismatch raises module-changed, a vanished module module-missing.
// - A module fault raises the slot trip and writes its cause into the 8-bit error field, unless an overtemp edge comes in the same cycle.
// - Error value zero means no error, any other value means an error was seen.
// - A drive reset clears the error field to zero.
// - Above 90 C the fan is forced to full speed and held at least 10 s.
// - Below 90 C and after the hold the fan override is released.
// - Above 100 C the slot trip is raised and the error field loaded with 74.
// - Version is split into a major.minor field 0..9999 and a sub field 0..99.
// - A module without software shows both version fields as zero.
// - Codes 81..83 flag a link failure to slot 1..3, code 80 a general one.
// - Code 76 flags a modbus timeout and 75 an unresponsive drive.
// - Code 64 flags a missed expected packet rate.
module osb_status_bank
  import osb_pkg::*;
#(
  parameter longint FAN_HOLD_CYC = osb_pkg::OSB_FAN_HOLD_CYC
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // option module side
  input  wire logic        mod_present_i,
  input  wire logic [15:0] mod_type_i,
  input  wire logic        mod_has_sw_i,
  input  wire logic [15:0] mod_ver_i,
  input  wire logic [7:0]  mod_subver_i,
  input  wire logic        mod_err_we_i,
  input  wire logic [7:0]  mod_err_code_i,
  input  wire logic [7:0]  board_temp_i,
  // nonvolatile store of the saved type
  input  wire logic [15:0] nv_saved_type_i,
  output logic             nv_save_o,
  output logic [15:0]      nv_save_type_o,
  // drive outputs
  output logic             fan_full_o,
  output logic             slot_error_trip_o,
  output logic             module_changed_trip_o,
  output logic             module_missing_trip_o,
  output logic             irq_o
);
  localparam logic [31:0] OSB_VER_MAX = 32'd9999;
  localparam logic [7:0]  OSB_SUB_MAX = 8'd99;
  // refuse a hold the timer cannot count; zero would release the fan as soon as it cools
  if (FAN_HOLD_CYC < 1 || FAN_HOLD_CYC > 64'h0000_0000_ffff_ffff) begin : g_bad_hold
    $error("osb_status_bank: FAN_HOLD_CYC out of range");
  end

  // decoded and synchronised helpers
  logic        present_s;
  logic        fan_busy;
  logic        hot;
  logic        overtemp;
  logic        ptr_wr;
  logic        ptr_rd;
  logic        ptr_acc;

  // registered state, each with its next value, then the combinational irq set and clear vectors
  logic        init_done_r, init_done_nxt;
  logic [15:0] type_r, type_nxt;
  logic [15:0] ver_r, ver_nxt;
  logic [7:0]  subver_r, subver_nxt;
  logic [7:0]  err_r, err_nxt;
  logic        trip_err_r, trip_err_nxt;
  logic        trip_chg_r, trip_chg_nxt;
  logic        trip_mis_r, trip_mis_nxt;
  logic        save_armed_r, save_armed_nxt;
  logic        nv_save_r, nv_save_nxt;
  logic [15:0] save_cmd_r, save_cmd_nxt;
  logic        fan_r, fan_nxt;
  logic [OSB_IRQ_W-1:0] irq_st_r, irq_st_nxt;
  logic [OSB_IRQ_W-1:0] irq_en_r, irq_en_nxt;
  logic [OSB_IRQ_W-1:0] irq_set;
  logic [OSB_IRQ_W-1:0] irq_clr;
  logic [31:0] rdata_r, rdata_nxt;
  logic        slverr_r, slverr_nxt;
  logic        ovt_prev_r, ovt_prev_nxt;
  logic        fan_prev_r, fan_prev_nxt;
  logic        startup_r, startup_nxt;
  logic [2:0]  settle_r, settle_nxt;

  // presence is a pin from the slot connector, so it crosses domains
  osb_sync3 u_present_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .d_i       (mod_present_i),
    .q_o       (present_s)
  );

  // strict comparisons: a reading equal to a threshold does not act
  assign hot      = (board_temp_i > OSB_FAN_TEMP);
  assign overtemp = (board_temp_i > OSB_TRIP_TEMP);

  // hold timer restarts while hot, so the override outlives the last hot sample
  osb_hold_timer #(
    .HOLD_CYC (FAN_HOLD_CYC)
  ) u_fan_hold (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .trig_i    (hot),
    .busy_o    (fan_busy)
  );

  // apb decode; single-cycle access phase, no wait states
  assign ptr_acc = psel_i & penable_i;
  assign ptr_wr  = ptr_acc & pwrite_i;
  assign ptr_rd  = ptr_acc & ~pwrite_i;

  // identity capture: the first settled sample after reset stands for power-up
  always_comb begin
    startup_nxt   = 1'b0;
    settle_nxt    = settle_r;
    init_done_nxt = init_done_r;
    type_nxt      = type_r;
    ver_nxt       = ver_r;
    subver_nxt    = subver_r;
    trip_chg_nxt  = trip_chg_r;
    trip_mis_nxt  = trip_mis_r;
    if (!init_done_r) begin
      // the presence synchroniser is held empty in reset, so sampling at once
      // would always see an empty slot; wait until its output can be trusted
      if (settle_r != 3'(OSB_SYNC_SETTLE)) begin
        settle_nxt = settle_r + 3'h1;
      end else begin
        startup_nxt   = 1'b1;
        init_done_nxt = 1'b1;
        if (present_s) begin
          // out-of-range codes read as zero rather than a bogus type
          type_nxt = (mod_type_i <= OSB_TYPE_MAX) ? mod_type_i : 16'h0;
          if (mod_has_sw_i && 32'(mod_ver_i) <= OSB_VER_MAX &&
              mod_subver_i <= OSB_SUB_MAX) begin
            ver_nxt    = mod_ver_i;
            subver_nxt = mod_subver_i;
          end else begin
            ver_nxt    = 16'h0;
            subver_nxt = 8'h0;
          end
        end
      end
    end else if (!present_s) begin
      // slot emptied after start-up: all identity fields go to zero
      type_nxt   = 16'h0;
      ver_nxt    = 16'h0;
      subver_nxt = 8'h0;
    end
    // compare only on the start-up sample, against the saved code
    if (startup_r) begin
      if (nv_saved_type_i != 16'h0 && type_r == 16'h0) begin
        trip_mis_nxt = 1'b1;
      end else if (type_r != nv_saved_type_i && type_r != 16'h0) begin
        trip_chg_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      init_done_r <= 1'b0;
      settle_r    <= 3'h0;
      startup_r   <= 1'b0;
      type_r      <= 16'h0;
      ver_r       <= 16'h0;
      subver_r    <= 8'h0;
      trip_chg_r  <= 1'b0;
      trip_mis_r  <= 1'b0;
    end else begin
      init_done_r <= init_done_nxt;
      settle_r    <= settle_nxt;
      startup_r   <= startup_nxt;
      type_r      <= type_nxt;
      ver_r       <= ver_nxt;
      subver_r    <= subver_nxt;
      trip_chg_r  <= trip_chg_nxt;
      trip_mis_r  <= trip_mis_nxt;
    end
  end

  // error status and slot trip; reset clears via nrst_i
  // the overtemp edge wins a same-cycle module report, which is then lost
  always_comb begin
    err_nxt      = err_r;
    trip_err_nxt = trip_err_r;
    ovt_prev_nxt = overtemp;
    if (overtemp && !ovt_prev_r) begin
      err_nxt      = OSB_ERR_OVERTEMP;
      trip_err_nxt = 1'b1;
    end else if (mod_err_we_i && mod_err_code_i != OSB_ERR_NONE) begin
      // codes such as 64, 75, 76, 80..83 pass straight through
      err_nxt      = mod_err_code_i;
      trip_err_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      err_r      <= OSB_ERR_NONE;
      trip_err_r <= 1'b0;
      ovt_prev_r <= 1'b0;
    end else begin
      err_r      <= err_nxt;
      trip_err_r <= trip_err_nxt;
      ovt_prev_r <= ovt_prev_nxt;
    end
  end

  // fan override: set while hot, released only once cool and hold expired
  // exactly 90 degrees leaves the fan under normal control
  always_comb begin
    fan_nxt      = hot | fan_busy;
    fan_prev_nxt = fan_r;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      fan_r      <= 1'b0;
      fan_prev_r <= 1'b0;
    end else begin
      fan_r      <= fan_nxt;
      fan_prev_r <= fan_prev_nxt;
    end
  end

  // save: write 1000 to the save command, then a stop/reset strobe commits
  // a stop strobe without a prior arm does nothing, so a stray stop cannot save
  always_comb begin
    save_cmd_nxt   = save_cmd_r;
    save_armed_nxt = save_armed_r;
    nv_save_nxt    = 1'b0;
    if (ptr_wr && paddr_i == OSB_CTRL_OFS) begin
      if (pwdata_i[OSB_CTRL_STOP]) begin
        if (save_armed_r) begin
          nv_save_nxt    = 1'b1;
          save_armed_nxt = 1'b0;
          save_cmd_nxt   = 16'h0;
        end
      end else begin
        save_cmd_nxt   = pwdata_i[31:16];
        save_armed_nxt = (pwdata_i[31:16] == OSB_SAVE_CODE);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      save_cmd_r   <= 16'h0;
      save_armed_r <= 1'b0;
      nv_save_r    <= 1'b0;
    end else begin
      save_cmd_r   <= save_cmd_nxt;
      save_armed_r <= save_armed_nxt;
      nv_save_r    <= nv_save_nxt;
    end
  end

  // interrupts: events set sticky bits; set wins over a same-cycle clear
  always_comb begin
    irq_set = '0;
    irq_set[OSB_IRQ_ERR]     = trip_err_nxt & ~trip_err_r;
    irq_set[OSB_IRQ_CHANGED] = trip_chg_nxt & ~trip_chg_r;
    irq_set[OSB_IRQ_MISSING] = trip_mis_nxt & ~trip_mis_r;
    irq_set[OSB_IRQ_FAN]     = fan_r & ~fan_prev_r;
    irq_clr = '0;
    if (ptr_wr && paddr_i == OSB_IRQ_CLR_OFS) irq_clr = pwdata_i[OSB_IRQ_W-1:0];
    irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;
    irq_en_nxt = irq_en_r;
    if (ptr_wr && paddr_i == OSB_IRQ_EN_OFS) irq_en_nxt = pwdata_i[OSB_IRQ_W-1:0];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      irq_st_r <= '0;
      irq_en_r <= '0;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  // read mux; reads touch no state, so polling is harmless
  // unmapped offsets answer with pslverr and read as zero
  always_comb begin
    rdata_nxt  = 32'h0;
    slverr_nxt = 1'b0;
    if (psel_i && !penable_i) begin
      case (paddr_i)
        OSB_TYPE_OFS:    rdata_nxt = {16'h0, type_r};
        OSB_VER_OFS:     rdata_nxt = {16'h0, ver_r};
        OSB_ERR_OFS:     rdata_nxt = {24'h0, err_r};
        OSB_SUBVER_OFS:  rdata_nxt = {24'h0, subver_r};
        OSB_CTRL_OFS:    rdata_nxt = {save_cmd_r, 15'h0, save_armed_r};
        OSB_SAVED_OFS:   rdata_nxt = {16'h0, nv_saved_type_i};
        OSB_IRQ_ST_OFS:  rdata_nxt = {28'h0, irq_st_r};
        OSB_IRQ_EN_OFS:  rdata_nxt = {28'h0, irq_en_r};
        OSB_IRQ_CLR_OFS: rdata_nxt = 32'h0;
        OSB_TEMP_OFS:    rdata_nxt = {24'h0, board_temp_i};
        default:         slverr_nxt = 1'b1;
      endcase
    end else if (ptr_acc) begin
      rdata_nxt  = rdata_r;
      slverr_nxt = slverr_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rdata_r  <= 32'h0;
      slverr_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  // outputs
  assign prdata_o              = ptr_rd ? rdata_r : 32'h0;
  assign pready_o              = 1'b1;
  assign pslverr_o             = ptr_acc & slverr_r;
  assign nv_save_o             = nv_save_r;
  assign nv_save_type_o        = type_r;
  assign fan_full_o            = fan_r;
  assign slot_error_trip_o     = trip_err_r;
  assign module_changed_trip_o = trip_chg_r;
  assign module_missing_trip_o = trip_mis_r;
  assign irq_o                 = |(irq_st_r & irq_en_r);
endmodule : osb_status_bank
`default_nettype wire

// File: hw/osb_sync3.sv
// three-flop synchroniser; output changes when stages two and three agree
// assumes an asynchronous single-bit level
`timescale 1ns/10ps
`default_nettype none
module osb_sync3 (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic       q_r;
  logic       q_nxt;
  // first stage only feeds the second
  always_comb begin
    sh_nxt = {sh_r[1:0], d_i};
    q_nxt  = (sh_r[1] == sh_r[2]) ? sh_r[2] : q_r;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sh_r <= 3'h0;
      q_r  <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      q_r  <= q_nxt;
    end
  end
  assign q_o = q_r;
endmodule : osb_sync3
`default_nettype wire

// File: include/osb_pkg.sv
// package for the option slot status bank: register map, codes, timing
// assumes a 32-bit apb bus and a 100 mhz system clock
`default_nettype none
package osb_pkg;
  // register byte offsets
  localparam logic [7:0] OSB_TYPE_OFS    = 8'h00;
  localparam logic [7:0] OSB_VER_OFS     = 8'h04;
  localparam logic [7:0] OSB_ERR_OFS     = 8'h08;
  localparam logic [7:0] OSB_SUBVER_OFS  = 8'h0c;
  localparam logic [7:0] OSB_CTRL_OFS    = 8'h10;
  localparam logic [7:0] OSB_SAVED_OFS   = 8'h14;
  localparam logic [7:0] OSB_IRQ_ST_OFS  = 8'h18;
  localparam logic [7:0] OSB_IRQ_EN_OFS  = 8'h1c;
  localparam logic [7:0] OSB_IRQ_CLR_OFS = 8'h20;
  localparam logic [7:0] OSB_TEMP_OFS    = 8'h24;
  // field limits and codes
  localparam logic [15:0] OSB_TYPE_MAX     = 16'h0257;
  localparam logic [15:0] OSB_SAVE_CODE    = 16'h03e8;
  localparam logic [7:0]  OSB_ERR_NONE     = 8'h00;
  localparam logic [7:0]  OSB_ERR_PKT_RATE = 8'h40;
  localparam logic [7:0]  OSB_ERR_OVERTEMP = 8'h4a;
  localparam logic [7:0]  OSB_ERR_NO_DRIVE = 8'h4b;
  localparam logic [7:0]  OSB_ERR_MB_TMO   = 8'h4c;
  localparam logic [7:0]  OSB_ERR_INTEROPT = 8'h50;
  localparam logic [7:0]  OSB_ERR_SLOT1    = 8'h51;
  localparam logic [7:0]  OSB_ERR_SLOT3    = 8'h53;
  // temperatures in whole degrees c
  localparam logic [7:0]  OSB_FAN_TEMP     = 8'h5a;
  localparam logic [7:0]  OSB_TRIP_TEMP    = 8'h64;
  // irq status bit positions
  localparam int OSB_IRQ_ERR     = 0;
  localparam int OSB_IRQ_CHANGED = 1;
  localparam int OSB_IRQ_MISSING = 2;
  localparam int OSB_IRQ_FAN     = 3;
  localparam int OSB_IRQ_W       = 4;
  // ctrl bit positions
  localparam int OSB_CTRL_STOP   = 0;
  // timing
  localparam int OSB_CLK_HZ      = 100_000_000;
  localparam int OSB_FAN_HOLD_S  = 10;
  localparam longint OSB_FAN_HOLD_CYC = longint'(OSB_FAN_HOLD_S) * OSB_CLK_HZ;
  // cycles after reset before the synchronised presence level can be trusted
  localparam int OSB_SYNC_SETTLE  = 4;
endpackage : osb_pkg
`default_nettype wire

// File: testbench/osb_opt_model.sv
// option module and nonvolatile store as seen from the bank
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module osb_opt_model (
  // clock and save request
  input wire logic        sys_clk_i,
  input wire logic        nv_save_i,
  input wire logic [15:0] nv_save_type_i,
  // module levels
  output logic            present_o,
  output logic [15:0]     type_o,
  output logic            has_sw_o,
  output logic [15:0]     ver_o,
  output logic [7:0]      subver_o,
  output logic            err_we_o,
  output logic [7:0]      err_code_o,
  output logic [7:0]      temp_o,
  output logic [15:0]     nv_type_o
);
  // version stays driven even without software, so the bank must hide it
  assign ver_o    = 16'h04d2;
  assign subver_o = 8'h38;
  // the store starts with a type already saved
  initial begin
    err_we_o = 1'b0;
    err_code_o = 8'h00;
    temp_o = 8'h19;
    nv_type_o = 16'h0123;
  end
  // store takes the installed type on each save strobe
  always @(posedge sys_clk_i) if (nv_save_i) nv_type_o <= nv_save_type_i;
  task automatic setup(input logic p, input logic [15:0] t, input logic sw);
    present_o <= p;
    type_o <= t;
    has_sw_o <= sw;
  endtask : setup
  task automatic fault(input logic [7:0] c);
    @(posedge sys_clk_i);
    err_we_o <= 1'b1;
    err_code_o <= c;
    @(posedge sys_clk_i);
    err_we_o <= 1'b0;
    err_code_o <= ~c; // stale code is not left on the lines
  endtask : fault
  task automatic heat(input logic [7:0] t);
    temp_o <= t;
  endtask : heat
endmodule : osb_opt_model
`default_nettype wire

// File: testbench/osb_status_bank_asserts.sv
// checker for the status bank: trips, fan hold, save strobe, type range
// sees only the bank's ports; bound to every instance below its endmodule
`timescale 1ns/10ps
`default_nettype none
module osb_status_bank_asserts
  import osb_pkg::*;
#(
  parameter longint FAN_HOLD_CYC = 50
) (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  // module side and drive outputs
  input wire logic        mod_err_we_i,
  input wire logic [7:0]  mod_err_code_i,
  input wire logic [7:0]  board_temp_i,
  input wire logic        nv_save_o,
  input wire logic        fan_full_o,
  input wire logic        slot_error_trip_o,
  input wire logic        module_changed_trip_o,
  input wire logic        module_missing_trip_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [31:0] cool_r;
  logic        save_wr_r;
  // cycles since the last hot sample; saturates so a long idle cannot wrap
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || board_temp_i > OSB_FAN_TEMP) cool_r <= 32'h0;
    else if (cool_r != 32'hffff_ffff) cool_r <= cool_r + 32'h1;
    save_wr_r <= nrst_i && psel_i && penable_i && pwrite_i && paddr_i == OSB_CTRL_OFS
                 && pwdata_i[0];
  end
  property p_type_max;
    psel_i && penable_i && !pwrite_i && paddr_i == OSB_TYPE_OFS
      |-> prdata_o <= {16'h0, OSB_TYPE_MAX};
  endproperty
  a_type_max: assert property (p_type_max) else $error("type field out of range");
  property p_err_trip;
    mod_err_we_i && mod_err_code_i != OSB_ERR_NONE |=> slot_error_trip_o;
  endproperty
  a_err_trip: assert property (p_err_trip) else $error("fault gave no trip");
  property p_hot_trip;
    board_temp_i > OSB_TRIP_TEMP |=> slot_error_trip_o;
  endproperty
  a_hot_trip: assert property (p_hot_trip) else $error("overheat gave no trip");
  property p_fan_on;
    board_temp_i > OSB_FAN_TEMP |=> fan_full_o;
  endproperty
  a_fan_on: assert property (p_fan_on) else $error("fan not forced");
  property p_fan_hold;
    $fell(fan_full_o) |-> cool_r >= FAN_HOLD_CYC - 1;
  endproperty
  a_fan_hold: assert property (p_fan_hold) else $error("fan released early");
  property p_rst_clear;
    !$past(nrst_i) |-> !(slot_error_trip_o || fan_full_o || nv_save_o
                         || module_changed_trip_o || module_missing_trip_o);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("output set after reset");
  property p_save_cause;
    nv_save_o |-> save_wr_r ##1 !nv_save_o;
  endproperty
  a_save_cause: assert property (p_save_cause) else $error("stray save strobe");
  property p_trip_excl;
    !(module_changed_trip_o && module_missing_trip_o);
  endproperty
  a_trip_excl: assert property (p_trip_excl) else $error("both power-up trips");
endmodule : osb_status_bank_asserts
bind osb_status_bank osb_status_bank_asserts #(.FAN_HOLD_CYC(FAN_HOLD_CYC)) u_osb_chk (
  .sys_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .mod_err_we_i, .mod_err_code_i, .board_temp_i, .nv_save_o, .fan_full_o,
  .slot_error_trip_o, .module_changed_trip_o, .module_missing_trip_o);
`default_nettype wire

// File: testbench/osb_status_bank_tb.sv
// bench for the status bank: reads, faults, irq, fan, save, power-up trips
// assumes 100 mhz and the fan hold shortened to 50 cycles
`timescale 1ns/10ps
`default_nettype none
module osb_status_bank_tb;
  import osb_pkg::*;
  localparam longint HOLD = 50;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} osb_row_t;
  logic        sys_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rerr;
  logic [7:0]  paddr_i, mod_subver_i, mod_err_code_i, board_temp_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic [15:0] mod_type_i, mod_ver_i, nv_saved_type_i, nv_save_type_o;
  logic        mod_present_i, mod_has_sw_i, mod_err_we_i, nv_save_o, fan_full_o, irq_o;
  logic        slot_error_trip_o, module_changed_trip_o, module_missing_trip_o;
  int          fail_count, check_count;
  osb_row_t    rows [9] = '{'{OSB_TYPE_OFS, 32'h123, 1'b0}, '{OSB_VER_OFS, 32'h4d2, 1'b0},
    '{OSB_SUBVER_OFS, 32'h38, 1'b0}, '{OSB_ERR_OFS, 32'h0, 1'b0},
    '{OSB_SAVED_OFS, 32'h123, 1'b0}, '{OSB_TEMP_OFS, 32'h19, 1'b0}, '{8'h28, 32'h0, 1'b1},
    '{OSB_IRQ_ST_OFS, 32'h0, 1'b0}, '{OSB_CTRL_OFS, 32'h0, 1'b0}};
  logic [7:0]  codes [7] = '{OSB_ERR_PKT_RATE, OSB_ERR_NO_DRIVE, OSB_ERR_MB_TMO,
    OSB_ERR_INTEROPT, OSB_ERR_SLOT1, 8'h52, OSB_ERR_SLOT3};
  osb_status_bank #(.FAN_HOLD_CYC(HOLD)) dut (.sys_clk_i, .nrst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mod_present_i,
    .mod_type_i, .mod_has_sw_i, .mod_ver_i, .mod_subver_i, .mod_err_we_i, .mod_err_code_i,
    .board_temp_i, .nv_saved_type_i, .nv_save_o, .nv_save_type_o, .fan_full_o,
    .slot_error_trip_o, .module_changed_trip_o, .module_missing_trip_o, .irq_o);
  osb_opt_model opt (.sys_clk_i, .nv_save_i(nv_save_o), .nv_save_type_i(nv_save_type_o),
    .present_o(mod_present_i), .type_o(mod_type_i), .has_sw_o(mod_has_sw_i),
    .ver_o(mod_ver_i), .subver_o(mod_subver_i), .err_we_o(mod_err_we_i),
    .err_code_o(mod_err_code_i), .temp_o(board_temp_i), .nv_type_o(nv_saved_type_i));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rdat, e);
  endtask : rd
  // two-cycle reset, then room for the settled start-up sample and the compare
  task automatic restart();
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
  endtask : restart
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin : watchdog
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    finish_test();
  end
  initial begin : main
    {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    fail_count = 0;
    check_count = 0;
    opt.setup(1'b1, 16'h0123, 1'b1);
    restart();
    foreach (rows[i]) begin
      rd("rdata", rows[i].a, rows[i].d);
      chk("slverr", 32'(rerr), 32'(rows[i].e));
    end
    chk("boot_trips", 32'({module_changed_trip_o, module_missing_trip_o}), 32'h0);
    $display("test reads done");
    apb(1'b1, OSB_IRQ_EN_OFS, 32'h1);
    foreach (codes[i]) begin
      opt.fault(codes[i]);
      rd("err", OSB_ERR_OFS, {24'h0, codes[i]});
    end
    rd("err_again", OSB_ERR_OFS, 32'h53);
    chk("trip", 32'(slot_error_trip_o), 32'h1);
    chk("irq", 32'(irq_o), 32'h1);
    opt.fault(8'h00);
    apb(1'b1, OSB_ERR_OFS, 32'h0);
    rd("err_kept", OSB_ERR_OFS, 32'h53);
    apb(1'b1, OSB_IRQ_EN_OFS, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    chk("irq_masked", 32'(irq_o), 32'h0);
    apb(1'b1, OSB_IRQ_CLR_OFS, 32'hf);
    apb(1'b1, OSB_IRQ_EN_OFS, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    chk("irq_cleared", 32'(irq_o), 32'h0);
    $display("test faults done");
    opt.heat(8'h5b);
    repeat (3) @(posedge sys_clk_i);
    chk("fan_on", 32'(fan_full_o), 32'h1);
    opt.heat(8'h5a);
    repeat (HOLD - 5) @(posedge sys_clk_i);
    chk("fan_held", 32'(fan_full_o), 32'h1);
    repeat (15) @(posedge sys_clk_i);
    chk("fan_off", 32'(fan_full_o), 32'h0);
    rd("irq_fan", OSB_IRQ_ST_OFS, 32'h8);
    opt.heat(8'h65);
    repeat (3) @(posedge sys_clk_i);
    rd("err_hot", OSB_ERR_OFS, {24'h0, OSB_ERR_OVERTEMP});
    opt.heat(8'h19);
    $display("test heat done");
    opt.setup(1'b1, 16'h0124, 1'b0);
    restart();
    chk("changed", 32'({module_changed_trip_o, module_missing_trip_o}), 32'h2);
    chk("trip_rst", 32'(slot_error_trip_o), 32'h0);
    rd("err_rst", OSB_ERR_OFS, 32'h0);
    rd("ver_nosw", OSB_VER_OFS, 32'h0);
    rd("sub_nosw", OSB_SUBVER_OFS, 32'h0);
    apb(1'b1, OSB_CTRL_OFS, {OSB_SAVE_CODE, 16'h0});
    apb(1'b1, OSB_CTRL_OFS, {OSB_SAVE_CODE, 16'h1});
    repeat (3) @(posedge sys_clk_i);
    chk("saved", 32'(nv_saved_type_i), 32'h124);
    $display("test save done");
    opt.setup(1'b0, 16'h0124, 1'b1);
    restart();
    chk("missing", 32'({module_changed_trip_o, module_missing_trip_o}), 32'h1);
    rd("type_empty", OSB_TYPE_OFS, 32'h0);
    $display("test empty slot done");
    finish_test();
  end
endmodule : osb_status_bank_tb
`default_nettype wire
